// *** hw/crs_steer.sv ***
`timescale 1ns/1ps
module crs_steer
	import crs_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [CRS_ADDR_W-1:0] reg_addr_i,
	input wire logic [CRS_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [CRS_DATA_W-1:0] reg_rdata_o,
	// Acceptance event from filter logic
	input wire logic accept_i,
	input wire logic [3:0] accept_filter_i,
	// Steering result
	output crs_route_t route_o,
	// Configuration outputs
	output logic [5:0] buf_count_o,
	output logic [4:0] fifo_start_o,
	output logic cfg_error_o
);

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] fifo_ctrl_r;
	logic [15:0] ptr_lo_r;
	logic [15:0] ptr_hi_r;
	logic [15:0] rdata_r;
	crs_route_t route_r;
	crs_route_t route_nxt;
	logic [7:0] fifo_hits_r;
	logic [7:0] buf_hits_r;
	logic [15:0] last_r;

	// ****************************************
	// Address decode
	// ****************************************
	wire wr_fifo_ctrl = reg_wr_i && (reg_addr_i == CRS_FIFO_CTRL_OFS);
	wire wr_ptr_lo = reg_wr_i && (reg_addr_i == CRS_PTR_4_7_OFS);
	wire wr_ptr_hi = reg_wr_i && (reg_addr_i == CRS_PTR_8_11_OFS);
	wire wr_steer_ctrl = reg_wr_i && (reg_addr_i == CRS_STEER_CTRL_OFS);

	// ****************************************
	// Configuration decode
	// ****************************************
	wire [2:0] cnt_sel = fifo_ctrl_r[CRS_CNT_SEL_LSB +: 3];
	wire [4:0] fstart = fifo_ctrl_r[CRS_FSTART_LSB +: 5];
	wire cnt_rsvd;
	wire [5:0] buf_count;

	crs_count_dec u_count_dec (
		.cnt_sel_i(cnt_sel),
		.buf_count_o(buf_count),
		.rsvd_o(cnt_rsvd)
	);

	wire start_out = {1'b0, fstart} >= buf_count;
	wire cfg_err = cnt_rsvd || start_out;

	// ****************************************
	// Pointer lookup
	// ****************************************
	function automatic logic [3:0] crs_ptr_sel(input logic [31:0] ptrs, input logic [2:0] idx);
		crs_ptr_sel = ptrs[idx*CRS_PTR_W +: CRS_PTR_W];
	endfunction : crs_ptr_sel

	wire filt_in_range = (accept_filter_i >= 4'h4) && (accept_filter_i <= 4'hB);
	wire [3:0] filt_rel = accept_filter_i - 4'h4;
	wire [3:0] sel_ptr = crs_ptr_sel({ptr_hi_r, ptr_lo_r}, filt_rel[2:0]);
	wire to_fifo = (sel_ptr == CRS_PTR_FIFO);

	always_comb begin
		route_nxt = '0;
		if (accept_i && filt_in_range) begin
			route_nxt.valid = 1'b1;
			if (to_fifo) begin
				route_nxt.dest = CRS_DEST_FIFO;
				route_nxt.buf_num = fstart;
			end else begin
				route_nxt.dest = CRS_DEST_BUF;
				route_nxt.buf_num = {1'b0, sel_ptr};
			end
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	logic [15:0] rd_mux;
	always_comb begin
		unique case (reg_addr_i)
			CRS_FIFO_CTRL_OFS: rd_mux = fifo_ctrl_r;
			CRS_PTR_4_7_OFS: rd_mux = ptr_lo_r;
			CRS_PTR_8_11_OFS: rd_mux = ptr_hi_r;
			CRS_STEER_CTRL_OFS: rd_mux = {fifo_hits_r, buf_hits_r};
			CRS_STEER_STAT_OFS: rd_mux = last_r;
			CRS_CFG_STAT_OFS: rd_mux = {8'h00, cnt_rsvd, start_out, buf_count};
			default: rd_mux = 16'h0000;
		endcase
	end

	// ****************************************
	// Sequential state
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			fifo_ctrl_r <= CRS_FIFO_CTRL_RST;
			ptr_lo_r <= CRS_PTR_RST;
			ptr_hi_r <= CRS_PTR_RST;
		end else begin
			if (wr_fifo_ctrl)
				fifo_ctrl_r <= reg_wdata_i & CRS_FIFO_CTRL_WMASK;
			if (wr_ptr_lo)
				ptr_lo_r <= reg_wdata_i;
			if (wr_ptr_hi)
				ptr_hi_r <= reg_wdata_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			fifo_hits_r <= 8'h00;
			buf_hits_r <= 8'h00;
		end else if (wr_steer_ctrl) begin
			fifo_hits_r <= 8'h00;
			buf_hits_r <= 8'h00;
		end else if (route_nxt.valid) begin
			if (route_nxt.dest == CRS_DEST_FIFO)
				fifo_hits_r <= fifo_hits_r + 8'h01;
			else
				buf_hits_r <= buf_hits_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			route_r <= '0;
			last_r <= 16'h0000;
			rdata_r <= 16'h0000;
		end else begin
			route_r <= route_nxt;
			if (route_nxt.valid)
				last_r <= {4'h0, accept_filter_i, route_nxt};
			rdata_r <= reg_rd_i ? rd_mux : 16'h0000;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign route_o = route_r;
	assign buf_count_o = buf_count;
	assign fifo_start_o = fstart;
	assign cfg_error_o = cfg_err;

endmodule : crs_steer

// *** pkg/crs_pkg.sv ***
package crs_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int CRS_ADDR_W = 4;
	localparam int CRS_DATA_W = 16;
	localparam logic [3:0] CRS_FIFO_CTRL_OFS = 4'h0;
	localparam logic [3:0] CRS_PTR_4_7_OFS = 4'h1;
	localparam logic [3:0] CRS_PTR_8_11_OFS = 4'h2;
	localparam logic [3:0] CRS_STEER_CTRL_OFS = 4'h3;
	localparam logic [3:0] CRS_STEER_STAT_OFS = 4'h4;
	localparam logic [3:0] CRS_CFG_STAT_OFS = 4'h5;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int CRS_CNT_SEL_LSB = 13;
	localparam int CRS_FSTART_LSB = 0;
	localparam int CRS_PTR_W = 4;
	localparam int CRS_FILT_FIRST = 4;
	localparam int CRS_FILT_NUM = 8;
	localparam logic [15:0] CRS_FIFO_CTRL_RST = 16'h0000;
	localparam logic [15:0] CRS_PTR_RST = 16'h0000;
	localparam logic [15:0] CRS_FIFO_CTRL_WMASK = 16'hE01F;
	localparam logic [3:0] CRS_PTR_FIFO = 4'hF;
	localparam logic [2:0] CRS_CNT_RSVD = 3'h7;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		CRS_DEST_NONE = 2'b00,
		CRS_DEST_BUF = 2'b01,
		CRS_DEST_FIFO = 2'b10
	} crs_dest_t;

	typedef struct packed {
		logic valid;
		crs_dest_t dest;
		logic [4:0] buf_num;
	} crs_route_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} crs_bus_t;

endpackage : crs_pkg

// *** hw/crs_count_dec.sv ***
`timescale 1ns/1ps
module crs_count_dec
	import crs_pkg::*;
(
	// Selection code
	input wire logic [2:0] cnt_sel_i,
	// Decoded buffer count
	output logic [5:0] buf_count_o,
	output logic rsvd_o
);

	// ****************************************
	// Buffer count decode
	// ****************************************
	always_comb begin
		rsvd_o = 1'b0;
		unique case (cnt_sel_i)
			3'h0: buf_count_o = 6'h04;
			3'h1: buf_count_o = 6'h06;
			3'h2: buf_count_o = 6'h08;
			3'h3: buf_count_o = 6'h0C;
			3'h4: buf_count_o = 6'h10;
			3'h5: buf_count_o = 6'h18;
			3'h6: buf_count_o = 6'h20;
			3'h7: begin
				buf_count_o = 6'h20;
				rsvd_o = 1'b1;
			end
		endcase
	end

endmodule : crs_count_dec

// *** sim/crs_steer_checker.sv ***
`timescale 1ns/1ps
module crs_steer_checker
	import crs_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic accept_i,
	input wire logic [3:0] accept_filter_i,
	input wire crs_route_t route_o,
	input wire logic [5:0] buf_count_o,
	input wire logic [4:0] fifo_start_o,
	input wire logic cfg_error_o
);
	logic [31:0] ptr_r;
	wire wr0 = reg_wr_i && reg_addr_i == CRS_FIFO_CTRL_OFS;
	wire hit = accept_i && accept_filter_i inside {[4'h4:4'hB]};
	wire [3:0] nib = 4'(ptr_r >> {accept_filter_i[2:0] ^ 3'h4, 2'b00});
	wire [5:0] cnt_w = 6'((reg_wdata_i[13] ? 6 : 4) << reg_wdata_i[15:14]);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ptr_r <= '0;
		end else if (reg_wr_i && reg_addr_i == CRS_PTR_4_7_OFS) begin
			ptr_r[15:0] <= reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == CRS_PTR_8_11_OFS) begin
			ptr_r[31:16] <= reg_wdata_i;
		end
	end
	property p_cnt;
		wr0 && reg_wdata_i[15:13] != 3'h7 |=> buf_count_o == $past(cnt_w);
	endproperty
	a_cnt: assert property (p_cnt) else $error("buffer count wrong");
	property p_fst;
		wr0 |=> fifo_start_o == 5'($past(reg_wdata_i));
	endproperty
	a_fst: assert property (p_fst) else $error("fifo start wrong");
	property p_ptr;
		reg_wr_i && reg_addr_i == CRS_PTR_4_7_OFS ##1 reg_rd_i && reg_addr_i == CRS_PTR_4_7_OFS
			|=> reg_rdata_o == $past(reg_wdata_i, 2);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer readback wrong");
	property p_none;
		!hit |=> !route_o.valid;
	endproperty
	a_none: assert property (p_none) else $error("route without filter hit");
	property p_fifo;
		hit && nib == 4'hF |=> route_o.valid && route_o.dest == CRS_DEST_FIFO
			&& route_o.buf_num == fifo_start_o;
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo route wrong");
	property p_buf;
		hit && nib != 4'hF |=> route_o == {1'b1, CRS_DEST_BUF, 1'b0, $past(nib)};
	endproperty
	a_buf: assert property (p_buf) else $error("buffer route wrong");
	c_fifo: cover property (hit && nib == 4'hF);
	c_buf: cover property (hit && nib == 4'h0);
	c_err: cover property (cfg_error_o);
endmodule : crs_steer_checker
bind crs_steer crs_steer_checker u_chk (.*);

// *** sim/crs_node_model.sv ***
`timescale 1ns/1ps
module crs_node_model (
	input wire logic core_clk_i,
	output logic accept_o = 1'b0,
	output logic [3:0] accept_filter_o = 4'h0
);
	task automatic deliver(input logic [3:0] f);
		accept_o <= 1'b1;
		accept_filter_o <= f;
		@(posedge core_clk_i);
		accept_o <= 1'b0;
		accept_filter_o <= ~f;
	endtask : deliver
endmodule : crs_node_model

// *** sim/crs_steer_tb.sv ***
`timescale 1ns/1ps
module crs_steer_tb
	import crs_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic accept_i;
	logic [3:0] accept_filter_i;
	crs_route_t route_o;
	logic [5:0] buf_count_o;
	logic [4:0] fifo_start_o;
	logic cfg_error_o;
	logic [15:0] rd_q[$];
	crs_route_t rt_q[$];
	logic rd_seen = 1'b0;
	int fail_count = 0;
	int samples_checked = 0;
	logic [31:0] p;
	logic [4:0] fs;
	logic [3:0] n;
	int fh = 0;
	int bh = 0;
	logic [5:0] tbl [8] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h20};
	crs_steer uut (.*);
	crs_node_model src (.core_clk_i(core_clk_i), .accept_o(accept_i),
		.accept_filter_o(accept_filter_i));
	initial begin
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rd_q.push_back(e);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
	endtask : rd
	task automatic summarize();
		$display("Checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	always @(posedge core_clk_i) begin
		if (rd_seen) chk(rd_q.pop_front(), reg_rdata_o);
		if (route_o.valid === 1'b1) chk(16'(rt_q.pop_front()), 16'(route_o));
		rd_seen = reg_rd_i;
	end
	initial begin
		void'($urandom(62773));
		repeat (16) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge core_clk_i);
		for (int a = 0; a < 4; a++) begin
			rd(4'(a == 3 ? 15 : a), 16'h0000);
			@(posedge core_clk_i);
		end
		for (int c = 0; c < 8; c++) begin
			fs = 5'($urandom);
			wr(CRS_FIFO_CTRL_OFS, {3'(c), 8'($urandom), fs});
			rd(CRS_FIFO_CTRL_OFS, {3'(c), 8'h00, fs});
			chk({10'h0, tbl[c]}, {10'h0, buf_count_o});
			chk({11'h0, fs}, {11'h0, fifo_start_o});
			chk({15'h0, c == 7 || fs >= tbl[c]}, {15'h0, cfg_error_o});
		end
		fs = 5'h13;
		wr(CRS_FIFO_CTRL_OFS, {3'h6, 8'h00, fs});
		rd(CRS_FIFO_CTRL_OFS, {3'h6, 8'h00, fs});
		for (int r = 0; r < 2; r++) begin
			p = $urandom;
			p[3:0] = CRS_PTR_FIFO;
			p[19:16] = 4'h0;
			p[31:28] = 4'hE;
			wr(CRS_PTR_4_7_OFS, p[15:0]);
			rd(CRS_PTR_4_7_OFS, p[15:0]);
			wr(CRS_PTR_8_11_OFS, p[31:16]);
			rd(CRS_PTR_8_11_OFS, p[31:16]);
			for (int f = 0; f < 16; f++) begin
				n = 4'(p >> (4 * f - 16));
				if (f inside {[4:11]}) begin
					rt_q.push_back(n == CRS_PTR_FIFO ?
						{1'b1, CRS_DEST_FIFO, fs} : {1'b1, CRS_DEST_BUF, 1'b0, n});
					if (n == CRS_PTR_FIFO)
						fh++;
					else
						bh++;
				end
				src.deliver(4'(f));
				@(posedge core_clk_i);
			end
		end
		rd(CRS_STEER_CTRL_OFS, {8'(fh), 8'(bh)});
		wr(CRS_STEER_CTRL_OFS, 16'h0000);
		rd(CRS_STEER_CTRL_OFS, 16'h0000);
		rd(CRS_STEER_STAT_OFS, {4'h0, 4'hB, 1'b1, CRS_DEST_BUF, 5'h0E});
		rd(CRS_CFG_STAT_OFS, {10'h000, 6'h20});
		repeat (3) @(posedge core_clk_i);
		chk(16'h0000, 16'(rt_q.size()));
		summarize();
	end
	initial begin
		repeat (2000) @(posedge core_clk_i);
		fail_count++;
		summarize();
	end
endmodule : crs_steer_tb
